// ### common/btr_pkg.sv
// Package for the board trigger and reset control block
package btr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NCH    = 8;
  localparam int SW     = 12;
  localparam int NGP    = 16;
  localparam int PW     = 17;
  localparam int IRQ_W  = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFF_TRIG_CFG = 8'h00;
  localparam logic [7:0] OFF_THRESH   = 8'h04;
  localparam logic [7:0] OFF_TSRC     = 8'h08;
  localparam logic [7:0] OFF_TOUT     = 8'h0C;
  localparam logic [7:0] OFF_SW_TRIG  = 8'h10;
  localparam logic [7:0] OFF_SW_CLEAR = 8'h14;
  localparam logic [7:0] OFF_GP_DIR   = 8'h18;
  localparam logic [7:0] OFF_GP_SEL   = 8'h1C;
  localparam logic [7:0] OFF_GP_DAT   = 8'h20;
  localparam logic [7:0] OFF_GP_IN    = 8'h24;
  localparam logic [7:0] OFF_TTAG     = 8'h28;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h2C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h30;
  localparam logic [7:0] OFF_STATUS   = 8'h34;

  ////////////////////////////////////////////////////////////////////////////
  // Bit positions
  localparam int PIN_EXT   = 16;
  localparam int GP_MEMFUL = 8;
  localparam int GP_EVRDY  = 9;
  localparam int GP_CHTRIG = 10;
  localparam int GP_RUN    = 11;
  localparam int GP_TTRST  = 12;
  localparam int GP_MCLR   = 13;
  localparam int IRQ_GTRIG = 0;
  localparam int IRQ_EXT   = 1;
  localparam int IRQ_TTRST = 2;
  localparam int IRQ_MCLR  = 3;
  localparam int IRQ_OVF   = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Sample group sizes
  localparam logic [2:0] GRP_STD  = 3'h4;
  localparam logic [2:0] GRP_PACK = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // Register layouts
  typedef struct packed {
    logic [15:0] rsv1;
    logic [7:0]  nth;
    logic [5:0]  rsv0;
    logic        packed_sample_mode;
    logic        falling;
  } btr_cfg_t;

  typedef struct packed {
    logic        ext_en;
    logic        sw_en;
    logic [2:0]  rsv1;
    logic [2:0]  coinc;
    logic [15:0] rsv0;
    logic [7:0]  chan_en;
  } btr_src_t;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam btr_cfg_t    CFG_RST   = btr_cfg_t'(32'h0000_0100);
  localparam logic [11:0] THR_RST   = 12'h800;
  localparam btr_src_t    TSRC_RST  = btr_src_t'(32'hC000_0000);
  localparam btr_src_t    TOUT_RST  = btr_src_t'(32'hC000_0000);
  localparam logic [15:0] GPDIR_RST = 16'h0FFF;
  localparam logic [15:0] GPSEL_RST = 16'hFFFF;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } btr_bus_t;

  typedef struct packed {
    logic mem_full;
    logic evt_ready;
    logic run;
  } btr_brd_t;

  typedef logic [NCH-1:0][SW-1:0] btr_samples_t;

  typedef struct packed {
    logic [2:0] samp_cnt;
    logic [7:0] grp_cnt;
    logic       qual;
  } btr_ch_st_t;

  typedef struct packed {
    btr_cfg_t          cfg;
    logic [SW-1:0]     thr;
    btr_src_t          src;
    btr_src_t          tout;
    logic [NGP-1:0]    gp_dir;
    logic [NGP-1:0]    gp_sel;
    logic [NGP-1:0]    gp_dat;
    logic [NGP-1:0]    gpo;
    logic [IRQ_W-1:0]  irq_mask;
    logic [IRQ_W-1:0]  irq_stat;
    logic [PW-1:0]     ps1;
    logic [PW-1:0]     ps2;
    logic [PW-1:0]     ps3;
    logic [PW-1:0]     pf;
    logic [30:0]       tt_cnt;
    logic              tt_ovf;
    logic              run_prev;
    logic [NCH-1:0]    qual_prev;
    logic [NCH-1:0]    loc;
    logic              gtrig;
    logic              tout_o;
    logic              chtrig;
    logic              mclr;
    logic [31:0]       rdata;
  } btr_st_t;

endpackage

// ### sim/btr_fp_model.sv
// Front-panel source model: external trigger and active-low reset lines
`timescale 1ns/1ps
module btr_fp_model (
  // Clock
  input  wire logic        mclk_i,
  // Pulse requests: 0 ext trigger, 1 time-tag reset, 2 memory clear
  input  wire logic [2:0]  req_i,
  input  wire logic [3:0]  width_i,
  // Front-panel levels
  output logic             ext_trig_o,
  output logic [15:0]      lines_o
);
  int left [3];

  initial begin
    ext_trig_o = 1'b0;
    lines_o    = 16'hFFFF;
    left       = '{0, 0, 0};
  end

  ////////////////////////////////////////////////////////////////////////
  // Pulses land 7 ns after the edge, unaligned; idle lines pulled high
  always @(posedge mclk_i) begin
    for (int k = 0; k < 3; k++) begin
      if (req_i[k]) begin
        left[k] = int'(width_i);
      end else if (left[k] > 0) begin
        left[k] = left[k] - 1;
      end
    end
    #7;
    ext_trig_o  = (left[0] > 0);
    lines_o[12] = !(left[1] > 0);
    lines_o[13] = !(left[2] > 0);
  end
endmodule

// ### sim/test_board_trigger_and_reset_control.sv
// Self-checking bench for the board trigger and reset control block
`timescale 1ns/1ps
module test_board_trigger_and_reset_control import btr_pkg::*; ();
  logic         mclk_i    = 1'b0;
  logic         nrst_i    = 1'b0;
  btr_bus_t     bus_i     = '0;
  btr_samples_t samples_i = '0;
  btr_brd_t     board_i   = '0;
  logic [2:0]   req       = '0;
  logic [31:0]  rdata_o;
  logic [15:0]  gpio_o;
  logic [15:0]  gpio_oe_o;
  logic [15:0]  gpio_i;
  logic [15:0]  fp_lines;
  logic         fp_ext;
  logic         global_trig_o;
  logic         trigger_output_line_o;
  logic         mem_clear_o;
  logic [31:0]  time_tag_o;
  logic         irq_o;
  int           mismatches = 0;
  int           num_checks = 0;
  int           cycles     = 0;
  int           g;
  int           t;
  int           m;
  logic [31:0]  d;
  logic [31:0]  e;
  logic [7:0]   row_a [8] = '{OFF_TRIG_CFG, OFF_THRESH, OFF_TSRC, OFF_TOUT,
                              OFF_GP_DIR, OFF_GP_SEL, OFF_IRQ_MASK, 8'h3C};
  logic [31:0]  row_e [8] = '{32'h0000_0100, 32'h0000_0800, 32'hC000_0000,
                              32'hC000_0000, 32'h0000_0FFF, 32'h0000_FFFF,
                              32'h0000_0000, 32'h0000_0000};

  always #25 mclk_i = ~mclk_i;
  assign gpio_i = (gpio_oe_o & gpio_o) | (~gpio_oe_o & fp_lines);

  btr_top uut (
    .mclk_i                (mclk_i),
    .nrst_i                (nrst_i),
    .bus_i                 (bus_i),
    .rdata_o               (rdata_o),
    .samples_i             (samples_i),
    .board_i               (board_i),
    .ext_trig_i            (fp_ext),
    .gpio_i                (gpio_i),
    .gpio_o                (gpio_o),
    .gpio_oe_o             (gpio_oe_o),
    .global_trig_o         (global_trig_o),
    .trigger_output_line_o (trigger_output_line_o),
    .mem_clear_o           (mem_clear_o),
    .time_tag_o            (time_tag_o),
    .irq_o                 (irq_o)
  );

  btr_fp_model fp (
    .mclk_i     (mclk_i),
    .req_i      (req),
    .width_i    (4'h4),
    .ext_trig_o (fp_ext),
    .lines_o    (fp_lines)
  );

  ////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i) bus_i <= '{1'b1, 1'b0, a, v};
    @(posedge mclk_i) bus_i <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk_i) bus_i <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge mclk_i) bus_i <= '0;
    #1 v = rdata_o;
  endtask

  task automatic cnt(input int n);
    g = 0;
    t = 0;
    m = 0;
    repeat (n) begin
      #1;
      g += int'(global_trig_o === 1'b1);
      t += int'(trigger_output_line_o === 1'b1);
      m += int'(mem_clear_o === 1'b1);
      @(posedge mclk_i);
    end
    #1;
  endtask

  task automatic fire(input int k);
    @(posedge mclk_i) req[k] <= 1'b1;
    @(posedge mclk_i) req[k] <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge mclk_i) nrst_i <= 1'b0;
    @(posedge mclk_i);
    #1 check(mem_clear_o, 1'b1);
    check(gpio_oe_o, 16'h0FFF);
    check(time_tag_o, 32'h0);
    @(posedge mclk_i) nrst_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
  endtask

  task automatic run_rows();
    wr(8'h3C, 32'hFFFF_FFFF);
    for (int i = 0; i < 8; i++) begin
      rd(row_a[i], d);
      check(d, row_e[i]);
    end
    $display("test register defaults done");
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("[ERR] %0t run did not complete", $time);
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  initial begin
    do_reset();
    run_rows();
    wr(OFF_SW_TRIG, 32'h0);
    #1 check(global_trig_o, 1'b1);
    check(trigger_output_line_o, 1'b1);
    @(posedge mclk_i) bus_i <= '{1'b1, 1'b0, OFF_SW_TRIG, 32'h0};
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk_i);
      if (i == 1) bus_i <= '0;
      #1 check(global_trig_o, i < 2);
    end
    wr(OFF_TSRC, 32'h8000_0000);
    wr(OFF_SW_TRIG, 32'h0);
    cnt(3);
    check(g, 0);
    check(t, 1);
    $display("test software trigger done");
    wr(OFF_TSRC, 32'hC000_0000);
    wr(OFF_IRQ_STAT, 32'h1F);
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_SW_TRIG, 32'h0);
    cnt(3);
    check(irq_o, 1'b1);
    wr(OFF_IRQ_MASK, 32'h0);
    cnt(2);
    check(irq_o, 1'b0);
    rd(OFF_IRQ_STAT, d);
    check(d & 32'h1, 32'h1);
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_IRQ_STAT, 32'h1);
    cnt(2);
    check(irq_o, 1'b0);
    $display("test interrupt done");
    fire(0);
    cnt(10);
    check(g, 1);
    check(t, 1);
    wr(OFF_TSRC, 32'h4000_0000);
    fire(0);
    cnt(10);
    check(g, 0);
    wr(OFF_TSRC, 32'hC000_0000);
    $display("test external trigger done");
    board_i <= '{1'b1, 1'b0, 1'b1};
    cnt(3);
    check(gpio_o[11:8] & 4'b1011, 4'b1001);
    wr(OFF_GP_SEL, 32'h0);
    wr(OFF_GP_DAT, 32'h0000_00A5);
    cnt(2);
    check(gpio_o[7:0], 8'hA5);
    wr(OFF_GP_SEL, 32'hFFFF);
    repeat (20) @(posedge mclk_i);
    rd(OFF_TTAG, d);
    rd(OFF_TTAG, e);
    check(e - d, 32'h2);
    fire(1);
    cnt(8);
    rd(OFF_TTAG, d);
    check(d < 32'd16 && e >= 32'd16, 1'b1);
    wr(OFF_SW_CLEAR, 32'h0);
    #1 check(mem_clear_o, 1'b1);
    fire(2);
    cnt(10);
    check(m, 1);
    $display("test lines and resets done");
    wr(OFF_THRESH, 32'h100);
    for (int k = 0; k < 2; k++) begin
      wr(OFF_TRIG_CFG, k ? 32'h0000_0102 : 32'h0000_0100);
      wr(OFF_TSRC, 32'hC000_0001);
      samples_i <= '0;
      cnt(12);
      @(posedge mclk_i) samples_i[0] <= 12'h200;
      cnt(3 + k);
      check(g, 0);
      cnt(8);
      check(g, 1);
      check(t, 0);
      check(gpio_o[0], 1'b1);
    end
    wr(OFF_TRIG_CFG, 32'h0000_0100);
    wr(OFF_TSRC, 32'hC100_0003);
    samples_i <= '0;
    cnt(12);
    @(posedge mclk_i) samples_i[0] <= 12'h200;
    cnt(12);
    check(g, 0);
    @(posedge mclk_i) samples_i[1] <= 12'h200;
    cnt(12);
    check(g, 1);
    $display("test auto trigger done");
    wr(OFF_TSRC, 32'h0);
    do_reset();
    run_rows();
    tally_and_finish();
  end
endmodule

// ### src/btr_chan_trig.sv
// Per-channel threshold qualifier for the auto-trigger
`timescale 1ns/1ps
module btr_chan_trig import btr_pkg::*; (
  // Clock and reset
  input  wire logic          mclk_i,
  input  wire logic          rst_n_i,
  // Sample and settings
  input  wire logic [SW-1:0] sample_i,
  input  wire logic [SW-1:0] thr_i,
  input  wire logic          falling_i,
  input  wire logic          packed_i,
  input  wire logic [7:0]    nth_i,
  // Qualified over-threshold
  output logic               qual_o
);

  btr_ch_st_t q, d;
  logic       beyond;
  logic [2:0] gsize;

  ////////////////////////////////////////////////////////////////////////////
  // Group counting
  always_comb begin
    d      = q;
    beyond = falling_i ? (sample_i < thr_i) : (sample_i > thr_i); // RULE4
    gsize  = packed_i ? GRP_PACK : GRP_STD; // RULE4
    if (!beyond) begin
      d = '0;
    end else begin
      if (q.samp_cnt == gsize - 3'h1) begin
        d.samp_cnt = '0;
        if (q.grp_cnt != 8'hFF) begin
          d.grp_cnt = q.grp_cnt + 8'h01;
        end
      end else begin
        d.samp_cnt = q.samp_cnt + 3'h1;
      end
      d.qual = (d.grp_cnt >= nth_i); // RULE5
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign qual_o = q.qual;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_QUAL_BEYOND: assert property ( // RULE4
    @(posedge mclk_i) disable iff (!rst_n_i) qual_o |-> $past(beyond))
    else $error("qualified without threshold crossing");

  AST_QUAL_DROP: assert property ( // RULE4
    @(posedge mclk_i) disable iff (!rst_n_i) !beyond |=> !qual_o)
    else $error("qualified state kept after leaving threshold");

  AST_QUAL_LAG: assert property ( // RULE5
    @(posedge mclk_i) disable iff (!rst_n_i) $rose(qual_o) |-> (q.grp_cnt >= $past(nth_i)))
    else $error("qualified before minimum group count");

endmodule

// ### src/btr_top.sv
// Board trigger, front-panel line and reset control
//
// Functional notes
// RULE1 - One board trigger goes to all channels at once.
// RULE2 - External trigger is synchronised to the internal clock.
// RULE3 - A write to the software-trigger register makes a software trigger.
// RULE4 - Channel qualifies after staying beyond threshold for groups of 4 or 5.
// RULE5 - Local trigger lags the crossing by the programmed group count.
// RULE6 - Local triggers only feed the central global trigger logic. Here they also drive the trigger output line and front-panel line 10.
// RULE7 - Local trigger needs coincidence-level other channels over threshold.
// RULE8 - Software keeps coincidence level below enabled channel count.
// RULE9 - Global trigger is the OR of enabled sources, synchronised.
// RULE10 - Trigger output line with selectable sources, local trigger included.
// RULE11 - Sixteen front-panel lines with register-set direction and function.
// RULE12 - Default lines 0-7 trigger requests, 8-11 board status outputs.
// RULE13 - Default line 12 time-tag reset, 13 memory clear, active low.
// RULE14 - Time-tag reset pulse restarts the timestamp timer.
// RULE15 - Memory reset by software clear write or memory clear pulse.
// RULE16 - Global reset clears buffers, counters, errors and restores defaults.
// RULE17 - Time tag: 31 count bits plus overflow, cleared at start.
// RULE18 - Front-panel resets synchronised, acted on at a falling-edge pulse.
// RULE19 - Trigger request per channel is its registered qualified condition.
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module btr_top import btr_pkg::*; (
  // Clock and reset
  input  wire logic          mclk_i,
  input  wire logic          nrst_i,
  // Register port
  input  wire btr_bus_t      bus_i,
  output logic [31:0]        rdata_o,
  // Samples and board status
  input  wire btr_samples_t  samples_i,
  input  wire btr_brd_t      board_i,
  // Front-panel pins
  input  wire logic          ext_trig_i,
  input  wire logic [15:0]   gpio_i,
  output logic [15:0]        gpio_o,
  output logic [15:0]        gpio_oe_o,
  // Triggers, resets, interrupt
  output logic               global_trig_o,
  output logic               trigger_output_line_o,
  output logic               mem_clear_o,
  output logic [31:0]        time_tag_o,
  output logic               irq_o
);

  localparam btr_st_t ST_RST = '{
    cfg:     CFG_RST,
    thr:     THR_RST,
    src:     TSRC_RST,
    tout:    TOUT_RST,
    gp_dir:  GPDIR_RST,
    gp_sel:  GPSEL_RST,
    ps1:     '1,
    ps2:     '1,
    ps3:     '1,
    pf:      '1,
    mclr:    1'b1,
    default: '0
  };

  btr_st_t          q, d;
  logic [1:0]       rst_sync_q;
  logic             rst_n;
  logic [NCH-1:0]   qual;
  logic [PW-1:0]    agree;
  logic [PW-1:0]    chg;
  logic             ext_rise;
  logic             tt_rst;
  logic             mclr_in;
  logic             sw_trig;
  logic             sw_clr;
  logic             run_rise;
  logic [3:0]       ovr_cnt;
  logic [NCH-1:0]   loc_raw;
  logic [NGP-1:0]   func;
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_clr;
  logic             wr;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Channel qualifiers
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    btr_chan_trig u_ch (
      .mclk_i    (mclk_i),
      .rst_n_i   (rst_n),
      .sample_i  (samples_i[g]),
      .thr_i     (q.thr),
      .falling_i (q.cfg.falling),
      .packed_i  (q.cfg.packed_sample_mode),
      .nth_i     (q.cfg.nth),
      .qual_o    (qual[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d   = q;
    wr  = bus_i.wr;
    // Pin synchronisers
    d.ps1 = {ext_trig_i, gpio_i};
    d.ps2 = q.ps1;
    d.ps3 = q.ps2;
    agree = ~(q.ps2 ^ q.ps3); // RULE2
    d.pf  = (q.ps2 & agree) | (q.pf & ~agree);
    chg   = d.pf ^ q.pf;
    ext_rise = chg[PIN_EXT] & d.pf[PIN_EXT]; // RULE2
    tt_rst   = chg[GP_TTRST] & ~d.pf[GP_TTRST] & ~q.gp_dir[GP_TTRST]; // RULE13 RULE18
    mclr_in  = chg[GP_MCLR] & ~d.pf[GP_MCLR] & ~q.gp_dir[GP_MCLR]; // RULE13 RULE18
    // Strobes from writes
    sw_trig = wr && (bus_i.addr == OFF_SW_TRIG); // RULE3
    sw_clr  = wr && (bus_i.addr == OFF_SW_CLEAR); // RULE15
    // Coincidence
    ovr_cnt = '0;
    for (int i = 0; i < NCH; i++) begin
      ovr_cnt = ovr_cnt + {3'h0, qual[i]};
    end
    for (int i = 0; i < NCH; i++) begin
      loc_raw[i] = qual[i] & ~q.qual_prev[i]
                 & ((ovr_cnt - {3'h0, qual[i]}) >= {1'b0, q.src.coinc}); // RULE7
    end
    d.qual_prev = qual;
    d.loc       = loc_raw & q.src.chan_en; // RULE6
    // Global trigger and trigger output
    d.gtrig  = (ext_rise & q.src.ext_en) | (sw_trig & q.src.sw_en)
             | (|d.loc); // RULE9 RULE1
    d.tout_o = (ext_rise & q.tout.ext_en) | (sw_trig & q.tout.sw_en)
             | (|(loc_raw & q.tout.chan_en)); // RULE10
    d.chtrig = |d.loc;
    // Memory reset
    d.mclr = sw_clr | mclr_in; // RULE15
    // Time tag
    run_rise   = board_i.run & ~q.run_prev;
    d.run_prev = board_i.run;
    if (tt_rst || run_rise) begin
      d.tt_cnt = '0; // RULE14 RULE17
      d.tt_ovf = 1'b0;
    end else begin
      d.tt_cnt = q.tt_cnt + 31'h1; // RULE17
      d.tt_ovf = q.tt_ovf | (&q.tt_cnt);
    end
    // Front-panel line functions
    func            = '0;
    func[7:0]       = qual; // RULE12 RULE19
    func[GP_MEMFUL] = board_i.mem_full; // RULE12
    func[GP_EVRDY]  = board_i.evt_ready;
    func[GP_CHTRIG] = q.chtrig;
    func[GP_RUN]    = board_i.run;
    d.gpo = (func & q.gp_sel) | (q.gp_dat & ~q.gp_sel); // RULE11
    // Interrupt events
    irq_ev            = '0;
    irq_ev[IRQ_GTRIG] = q.gtrig;
    irq_ev[IRQ_EXT]   = ext_rise;
    irq_ev[IRQ_TTRST] = tt_rst;
    irq_ev[IRQ_MCLR]  = d.mclr;
    irq_ev[IRQ_OVF]   = &q.tt_cnt;
    irq_clr = '0;
    // Register writes
    if (wr) begin
      if (bus_i.addr == OFF_TRIG_CFG) begin
        d.cfg = btr_cfg_t'(bus_i.wdata);
      end else if (bus_i.addr == OFF_THRESH) begin
        d.thr = bus_i.wdata[SW-1:0];
      end else if (bus_i.addr == OFF_TSRC) begin
        d.src = btr_src_t'(bus_i.wdata);
      end else if (bus_i.addr == OFF_TOUT) begin
        d.tout = btr_src_t'(bus_i.wdata);
      end else if (bus_i.addr == OFF_GP_DIR) begin
        d.gp_dir = bus_i.wdata[NGP-1:0]; // RULE11
      end else if (bus_i.addr == OFF_GP_SEL) begin
        d.gp_sel = bus_i.wdata[NGP-1:0];
      end else if (bus_i.addr == OFF_GP_DAT) begin
        d.gp_dat = bus_i.wdata[NGP-1:0];
      end else if (bus_i.addr == OFF_IRQ_STAT) begin
        irq_clr = bus_i.wdata[IRQ_W-1:0];
      end else if (bus_i.addr == OFF_IRQ_MASK) begin
        d.irq_mask = bus_i.wdata[IRQ_W-1:0];
      end
    end
    d.irq_stat = (q.irq_stat & ~irq_clr) | irq_ev;
    // Register reads
    d.rdata = '0;
    if (bus_i.rd) begin
      if (bus_i.addr == OFF_TRIG_CFG) begin
        d.rdata = q.cfg;
      end else if (bus_i.addr == OFF_THRESH) begin
        d.rdata = {20'h0_0000, q.thr};
      end else if (bus_i.addr == OFF_TSRC) begin
        d.rdata = q.src;
      end else if (bus_i.addr == OFF_TOUT) begin
        d.rdata = q.tout;
      end else if (bus_i.addr == OFF_GP_DIR) begin
        d.rdata = {16'h0000, q.gp_dir};
      end else if (bus_i.addr == OFF_GP_SEL) begin
        d.rdata = {16'h0000, q.gp_sel};
      end else if (bus_i.addr == OFF_GP_DAT) begin
        d.rdata = {16'h0000, q.gp_dat};
      end else if (bus_i.addr == OFF_GP_IN) begin
        d.rdata = {16'h0000, q.pf[NGP-1:0]};
      end else if (bus_i.addr == OFF_TTAG) begin
        d.rdata = {q.tt_ovf, q.tt_cnt};
      end else if (bus_i.addr == OFF_IRQ_STAT) begin
        d.rdata = {27'h000_0000, q.irq_stat};
      end else if (bus_i.addr == OFF_IRQ_MASK) begin
        d.rdata = {27'h000_0000, q.irq_mask};
      end else if (bus_i.addr == OFF_STATUS) begin
        d.rdata = {16'h0000, q.loc, qual};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= ST_RST; // RULE16
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata_o               = q.rdata;
  assign gpio_o                = q.gpo;
  assign gpio_oe_o             = q.gp_dir; // RULE11
  assign global_trig_o         = q.gtrig; // RULE1
  assign trigger_output_line_o = q.tout_o;
  assign mem_clear_o           = q.mclr; // RULE16
  assign time_tag_o            = {q.tt_ovf, q.tt_cnt};
  assign irq_o                 = |(q.irq_stat & q.irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_SW_TRIG: assert property ( // RULE3
    @(posedge mclk_i) disable iff (!rst_n)
    (sw_trig && q.src.sw_en) |=> global_trig_o)
    else $error("software trigger write did not fire global trigger");

  AST_EXT_TRIG: assert property ( // RULE2
    @(posedge mclk_i) disable iff (!rst_n)
    ($rose(q.ps3[PIN_EXT]) && q.ps2[PIN_EXT] && q.src.ext_en && !q.pf[PIN_EXT])
    |=> global_trig_o)
    else $error("agreed external edge did not fire global trigger");

  AST_GTRIG_SRC: assert property ( // RULE9
    @(posedge mclk_i) disable iff (!rst_n)
    global_trig_o |-> ($past(ext_rise && q.src.ext_en) || $past(sw_trig && q.src.sw_en)
                       || ($past(q.qual_prev) != q.qual_prev && q.loc != '0)))
    else $error("global trigger without an enabled source");

  AST_COINC: assert property ( // RULE7
    @(posedge mclk_i) disable iff (!rst_n)
    (q.loc != '0) |-> ($past(ovr_cnt) > {1'b0, $past(q.src.coinc)}))
    else $error("local trigger below coincidence level");

  AST_LOC_MASK: assert property ( // RULE6
    @(posedge mclk_i) disable iff (!rst_n)
    (q.loc & ~$past(q.src.chan_en)) == '0)
    else $error("local trigger from a disabled channel");

  AST_TOUT: assert property ( // RULE10
    @(posedge mclk_i) disable iff (!rst_n)
    trigger_output_line_o |-> ($past(ext_rise && q.tout.ext_en)
                               || $past(sw_trig && q.tout.sw_en)
                               || ($past(loc_raw & q.tout.chan_en) != '0)))
    else $error("trigger output without a selected source");

  AST_TT_RST: assert property ( // RULE14
    @(posedge mclk_i) disable iff (!rst_n)
    tt_rst |=> (time_tag_o == 32'h0000_0000))
    else $error("time tag not cleared by reset pulse");

  AST_TT_INC: assert property ( // RULE17
    @(posedge mclk_i) disable iff (!rst_n)
    (rst_n && !tt_rst && !run_rise) |=> (q.tt_cnt == $past(q.tt_cnt) + 31'h1))
    else $error("time tag did not advance");

  AST_MCLR: assert property ( // RULE15
    @(posedge mclk_i) disable iff (!rst_n)
    (sw_clr || mclr_in) |=> mem_clear_o)
    else $error("memory clear not issued");

  AST_GPIO_TREQ: assert property ( // RULE19
    @(posedge mclk_i) disable iff (!rst_n)
    ($past(q.gp_sel[7:0]) == 8'hFF) |-> (gpio_o[7:0] == $past(qual)))
    else $error("trigger request lines do not follow qualifiers");

  AST_RST_DEF: assert property ( // RULE16
    @(posedge mclk_i) disable iff (!rst_n)
    $rose(rst_n) |-> (gpio_oe_o == GPDIR_RST && mem_clear_o && !global_trig_o))
    else $error("defaults not restored by reset");

  AST_IN_LINES: assert property ( // RULE13
    @(posedge mclk_i) disable iff (!rst_n)
    q.gp_dir[GP_TTRST] |-> !tt_rst)
    else $error("time-tag reset taken from an output line");

endmodule
